// ==== src/secsp_dev_end.sv ====
// Device end: opcode decoder, write latch, status and protection logic.
// Assumes link pins are asynchronous to clk; they are synchronised here.
// Operation
// - Opcode first; set, clear latch, status read
// - Decode status write, array read, write
// - ID opcodes pick page or lock by A10
// - Unknown opcode: ignore until next select
// - Only set-latch opcode sets latch, on deselect
// - Clear-latch opcode clears latch on deselect
// - Latch cleared by reset, clear, write completion
// - Status read anytime, repeats while selected
// - Busy bit high during write cycles
// - Writes refused while latch is clear
// - Protect bits guard selected array area
// - Lock bit with pin low refuses status write
// - Master sets latch, then sends status write
// - Status bits 6..4 read zero, 1..0 untouched
// - Deselect right after eighth data bit
// - Deselect starts timed cycle, then latch clears
// - Old protection holds until cycle completes
// - Lock bit clear: status write needs latch only
// - Hardware protection follows bit and pin
// - Protected region stays locked, rest writable
// - Protect codes: none, quarter, half, all
// - Reset clears latch, busy; keeps stored bits
// - Writes need whole bytes of clocks
//
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/100ps
module secsp_dev_end #(
  parameter int TW_CYCLES = secsp_pkg::TW_CYCLES_DEF
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  secsp_link_if.dev       link,
  output logic [7:0]      statusByte,
  output logic            cmdPulse,
  output logic [7:0]      cmdCode,
  output logic            lockSel,
  output logic            hwProtected,
  output logic            writeStart
);
  // Decoder states, one-hot.
  typedef enum logic [6:0] {
    D_IDLE = 7'h01,  // Deselected, waiting for a select edge.
    D_OPC  = 7'h02,  // Shifting in the opcode.
    D_WAIT = 7'h04,  // Latch opcode taken, waiting for deselect.
    D_STAT = 7'h08,  // Streaming the status byte out.
    D_SWR  = 7'h10,  // Taking the status data byte.
    D_DATA = 7'h20,  // Address and data phase of other commands.
    D_IGN  = 7'h40   // Frame ignored until the next select.
  } secsp_dstate_e;

  localparam int TWW = $clog2(TW_CYCLES + 1);
  localparam logic [TWW-1:0] TW_LOAD = TWW'(TW_CYCLES - 1);

  logic [3:0]    syncA_q;     // First stage: sclk, csN, mosi, wpN.
  logic [3:0]    syncB_q;     // Second stage, the only one read.
  logic          sclkOld_q;   // Delayed clock for edge finding.
  logic          csOld_q;     // Delayed select for edge finding.
  secsp_dstate_e st_q;        // Decoder state.
  logic [2:0]    bitCnt_q;    // Bit within the current byte.
  logic [2:0]    byteCnt_q;   // Whole bytes seen, saturating.
  logic [7:0]    shIn_q;      // Input shift register.
  logic [7:0]    shOut_q;     // Output shift register.
  logic [2:0]    outCnt_q;    // Bit within the outgoing byte.
  logic [7:0]    opc_q;       // Opcode of the frame.
  logic [1:0]    addrTop_q;   // Address bits 17 and 16.
  logic          a10_q;       // Address bit 10 for ID commands.
  logic          wel_q;       // Write enable latch.
  logic          busy_q;      // Self-timed cycle running.
  logic          swCycle_q;   // Running cycle is a status write.
  logic [TWW-1:0] twCnt_q;    // Cycles left in the timed cycle.
  logic [2:0]    pend_q;      // New lock bit and protect bits.
  logic          cmd_q;       // One-cycle opcode-decoded pulse.
  logic          wstart_q;    // One-cycle write-start pulse.
  // Stored bits have no reset: they model non-volatile cells.
  logic [1:0]    bp_q   = secsp_pkg::BP_INIT;
  logic          lock_q = secsp_pkg::LOCK_INIT;

  // Named views of the synchronised pins and their edges.
  wire sclkS  = syncB_q[0];
  wire csS    = syncB_q[1];
  wire mosiS  = syncB_q[2];
  wire wpS    = syncB_q[3];
  wire rise   = sclkS & ~sclkOld_q & ~csS;
  wire fall   = ~sclkS & sclkOld_q & ~csS;
  wire csFall = ~csS & csOld_q;
  wire csRise = csS & ~csOld_q;
  wire [7:0] byteNow  = {shIn_q[6:0], mosiS};
  wire       byteDone = rise & (bitCnt_q == 3'h7);
  wire aligned = (bitCnt_q == 3'h0);

  // Protection follows bit and pin at once, either order.
  wire hardware_protected_mode = lock_q & ~wpS;

  // Status byte layout; bits 6..4 read zero.
  wire [7:0] status = {lock_q, 3'h0, bp_q, wel_q, busy_q};

  // Returns high when an address top falls in the protected area.
  function automatic logic inProtected(input logic [1:0] bp,
                                       input logic [1:0] top);
    case (bp)
      2'h1:    inProtected = (top == 2'h3);
      2'h2:    inProtected = top[1];
      2'h3:    inProtected = 1'b1;
      default: inProtected = 1'b0;
    endcase
  endfunction

  // Decode, ID commands share opcodes, A10 picks later.
  wire isWrOp  = (opc_q == secsp_pkg::OP_ARR_WR) |
                 (opc_q == secsp_pkg::OP_ID_WR);
  wire isArrWr = (opc_q == secsp_pkg::OP_ARR_WR);
  // Array protect; ID writes blocked only for full protect.
  wire regionLocked = isArrWr ? inProtected(bp_q, addrTop_q)
                              : (bp_q == 2'h3);
  wire arrOk = isWrOp & aligned & (byteCnt_q >= secsp_pkg::WR_MIN_BYTES)
               & wel_q & ~busy_q & ~regionLocked;
  // Status write acceptance: exact length, latch set.
  wire swOk  = aligned & (byteCnt_q == secsp_pkg::SW_BYTES)
               & wel_q & ~busy_q & ~hardware_protected_mode;

  // Two-flop synchronisers for every link input.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      syncA_q   <= 4'h2;
      syncB_q   <= 4'h2;
      sclkOld_q <= 1'b0;
      csOld_q   <= 1'b1;
    end else begin
      syncA_q   <= {link.wpN, link.mosi, link.csN, link.sclk};
      syncB_q   <= syncA_q;
      sclkOld_q <= sclkS;
      csOld_q   <= csS;
    end
  end

  // Bit and byte counting on the serial clock rise.
  always_ff @(posedge clk) begin
    if (!nrst || csFall) begin
      bitCnt_q  <= 3'h0;
      byteCnt_q <= 3'h0;
      shIn_q    <= 8'h00;
    end else if (rise) begin
      bitCnt_q <= bitCnt_q + 3'h1;
      shIn_q   <= byteNow;
      if (byteDone && byteCnt_q != 3'h7) begin
        byteCnt_q <= byteCnt_q + 3'h1;
      end
    end
  end

  // Frame sequencer. A deselect always returns to idle, so a frame
  // cut short leaves nothing half done behind it.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q      <= D_IDLE;
      opc_q     <= 8'h00;
      addrTop_q <= 2'h0;
      a10_q     <= 1'b0;
      cmd_q     <= 1'b0;
    end else begin
      cmd_q <= 1'b0;
      if (csRise) begin
        st_q <= D_IDLE;
      end else if (csFall) begin
        // Selection needs a falling edge after reset or deselect.
        st_q <= D_OPC;
      end else if (byteDone) begin
        case (st_q)
          D_OPC: begin
            opc_q <= byteNow;
            cmd_q <= 1'b1;
            case (byteNow)
              secsp_pkg::OP_SET_WEL,
              secsp_pkg::OP_CLR_WEL: st_q <= D_WAIT;
              secsp_pkg::OP_STAT_RD: st_q <= D_STAT;
              secsp_pkg::OP_STAT_WR: st_q <= D_SWR;
              secsp_pkg::OP_ARR_WR,
              secsp_pkg::OP_ID_WR:   st_q <= D_DATA;
              // Reads are not taken during a write cycle.
              secsp_pkg::OP_ARR_RD,
              secsp_pkg::OP_ID_RD:   st_q <= busy_q ? D_IGN : D_DATA;
              default:               st_q <= D_IGN;
            endcase
          end
          D_DATA: begin
            // Capture the address bits that steer protection.
            if (byteCnt_q == 3'h1) begin
              addrTop_q <= byteNow[1:0];
            end
            // A10 selects ID page or lock status.
            if (byteCnt_q == 3'h2) begin
              a10_q <= byteNow[2];
            end
          end
          // Extra bits after the latch opcode spoil the frame.
          D_WAIT:  st_q <= D_IGN;
          default: st_q <= st_q;
        endcase
      end
    end
  end

  // Status streaming on the serial clock fall; the byte is reloaded
  // every eighth bit so a polling master sees live busy status.
  always_ff @(posedge clk) begin
    if (!nrst || csFall) begin
      shOut_q  <= 8'h00;
      outCnt_q <= 3'h0;
    end else if (fall && st_q == D_STAT) begin
      // Repeat the status byte while selected.
      shOut_q  <= (outCnt_q == 3'h0) ? status : {shOut_q[6:0], 1'b0};
      outCnt_q <= outCnt_q + 3'h1;
    end
  end

  // Latch, busy timer and stored protection bits.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      // Reset clears latch and busy, stored bits untouched.
      wel_q     <= 1'b0;
      busy_q    <= 1'b0;
      swCycle_q <= 1'b0;
      twCnt_q   <= '0;
      pend_q    <= 3'h0;
      wstart_q  <= 1'b0;
    end else begin
      wstart_q <= 1'b0;
      if (busy_q) begin
        twCnt_q <= twCnt_q - TWW'(1);
        if (twCnt_q == '0) begin
          busy_q <= 1'b0;
          wel_q  <= 1'b0;
          // New protection takes effect only now.
          if (swCycle_q) begin
            lock_q <= pend_q[2];
            bp_q   <= pend_q[1:0];
          end
        end
      end
      if (csRise) begin
        // Latch changes only on an exact one-byte frame.
        if (st_q == D_WAIT && aligned && byteCnt_q == 3'h1) begin
          wel_q <= (opc_q == secsp_pkg::OP_SET_WEL);
        end
        // Deselect starts the timed status cycle; busy.
        if (st_q == D_SWR && swOk) begin
          busy_q    <= 1'b1;
          swCycle_q <= 1'b1;
          twCnt_q   <= TW_LOAD;
          // Only lock and protect bits are written.
          pend_q    <= {shIn_q[secsp_pkg::ST_LOCK],
                        shIn_q[secsp_pkg::ST_BP1],
                        shIn_q[secsp_pkg::ST_BP0]};
        end
        // Array and ID writes also hold busy for the cycle.
        if (st_q == D_DATA && arrOk) begin
          busy_q    <= 1'b1;
          swCycle_q <= 1'b0;
          twCnt_q   <= TW_LOAD;
          wstart_q  <= 1'b1;
        end
      end
    end
  end

  // Output drive: miso only while streaming status.
  assign link.miso   = shOut_q[7];
  assign link.misoOe = (st_q == D_STAT) & ~csS;
  assign statusByte  = status;
  assign cmdPulse    = cmd_q;
  assign cmdCode     = opc_q;
  assign lockSel     = a10_q;
  assign hwProtected = hardware_protected_mode;
  assign writeStart  = wstart_q;
endmodule

// ==== src/secsp_host_end.sv ====
// Master end: APB slave registers that frame SPI transfers of 1..8 bytes.
// Assumes a single APB master; miso arrives from another clock domain.
`timescale 1ns/100ps
module secsp_host_end #(
  parameter int HALF = secsp_pkg::HALF_DIV
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  secsp_link_if.host       link,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);
  // Frame sequencer states, one-hot.
  typedef enum logic [3:0] {
    H_IDLE = 4'h1,  // No frame.
    H_LOW  = 4'h2,  // Clock low, data bit set up.
    H_HIGH = 4'h4,  // Clock high.
    H_GAP  = 4'h8   // Deselected gap after a frame.
  } secsp_hstate_e;

  secsp_hstate_e st_q;          // Sequencer state.
  logic [63:0]   tx_q;          // Outgoing bytes, first byte at top.
  logic [31:0]   rx_q;          // Last four bytes received.
  logic [3:0]    len_q;         // Frame length in bytes.
  logic [5:0]    bitsLeft_q;    // Bits still to send, minus one.
  logic [7:0]    div_q;         // Half-period counter.
  logic          wp_q;          // Level driven on the protect pin.
  logic          sclk_q;        // Serial clock out.
  logic          cs_q;          // Chip select out, active low.
  logic [1:0]    misoSync_q;    // Two-flop miso synchroniser.

  // APB decode; zero wait states, unmapped offsets answer an error.
  wire access  = psel & penable;
  wire set_write_latch_cmd    = access & pwrite & (st_q == H_IDLE);
  wire hitTxHi = (paddr == secsp_pkg::RA_TX_HI);
  wire hitTxLo = (paddr == secsp_pkg::RA_TX_LO);
  wire hitCtrl = (paddr == secsp_pkg::RA_CTRL);
  wire hitStat = (paddr == secsp_pkg::RA_STAT);
  wire hitRx   = (paddr == secsp_pkg::RA_RX);
  wire mapped  = hitTxHi | hitTxLo | hitCtrl | hitStat | hitRx;
  wire startGo = set_write_latch_cmd & hitCtrl & pwdata[secsp_pkg::CT_START] &
                 (pwdata[3:0] != 4'h0) & (pwdata[3:0] <= 4'h8);
  wire halfEnd = (div_q == 8'(HALF - 1));

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata  = hitTxHi ? tx_q[63:32] :
                   hitTxLo ? tx_q[31:0] :
                   hitCtrl ? {26'h0, wp_q, 1'b0, len_q} :
                   hitStat ? {31'h0, (st_q != H_IDLE)} :
                   hitRx   ? rx_q : 32'h0;

  // Register writes; a busy master ignores writes so a frame in
  // flight can never be corrupted by software.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      len_q <= 4'h0;
      wp_q  <= 1'b1;
    end else if (set_write_latch_cmd && hitCtrl) begin
      len_q <= pwdata[3:0];
      wp_q  <= pwdata[secsp_pkg::CT_WP];
    end
  end

  // Miso is sampled only through its synchroniser.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      misoSync_q <= 2'h0;
    end else begin
      misoSync_q <= {misoSync_q[0], link.miso};
    end
  end

  // Frame sequencer. Miso is taken at the end of the high phase, late
  // enough to cover the device's synchroniser delay.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_q       <= H_IDLE;
      tx_q       <= 64'h0;
      rx_q       <= 32'h0;
      bitsLeft_q <= 6'h0;
      div_q      <= 8'h0;
      sclk_q     <= 1'b0;
      cs_q       <= 1'b1;
    end else begin
      div_q <= halfEnd ? 8'h0 : div_q + 8'h1;
      case (st_q)
        H_IDLE: begin
          div_q <= 8'h0;
          if (set_write_latch_cmd && hitTxHi) tx_q[63:32] <= pwdata;
          if (set_write_latch_cmd && hitTxLo) tx_q[31:0]  <= pwdata;
          // Software orders frames: latch set, then status write.
          if (startGo) begin
            cs_q       <= 1'b0;
            bitsLeft_q <= 6'({pwdata[3:0], 3'h0} - 7'h1);
            st_q       <= H_LOW;
          end
        end
        H_LOW: begin
          if (halfEnd) begin
            sclk_q <= 1'b1;
            st_q   <= H_HIGH;
          end
        end
        H_HIGH: begin
          if (halfEnd) begin
            rx_q   <= {rx_q[30:0], misoSync_q[1]};
            sclk_q <= 1'b0;
            tx_q   <= {tx_q[62:0], 1'b0};
            if (bitsLeft_q == 6'h0) begin
              // Deselect together with the last falling edge.
              cs_q <= 1'b1;
              st_q <= H_GAP;
            end else begin
              bitsLeft_q <= bitsLeft_q - 6'h1;
              st_q       <= H_LOW;
            end
          end
        end
        H_GAP: begin
          if (halfEnd) st_q <= H_IDLE;
        end
        default: st_q <= H_IDLE;
      endcase
    end
  end

  assign link.sclk = sclk_q;
  assign link.csN  = cs_q;
  assign link.mosi = tx_q[63];
  assign link.wpN  = wp_q;
endmodule

// ==== src/secsp_link_if.sv ====
// Serial link between the EEPROM command end and its bus master end.
// Assumes the bench joins both modports and resolves the data-out pin.
`timescale 1ns/100ps
interface secsp_link_if;
  logic sclk;       // Serial clock, idle low, made by the master.
  logic csN;        // Chip select, active low.
  logic mosi;       // Data from master, sampled on sclk rise.
  logic miso;       // Data from device, changed after sclk fall.
  logic misoOe;     // High while the device drives miso.
  logic wpN;        // Write protect, active low.
  modport dev  (input sclk, csN, mosi, wpN, output miso, misoOe);
  modport host (output sclk, csN, mosi, wpN, input miso, misoOe);
endinterface

// ==== src/secsp_pkg.sv ====
// Shared constants of the serial EEPROM command and protection link.
// Assumes both ends and the host register map are compiled after it.
package secsp_pkg;
  // Instruction codes carried by the first byte of every frame.
  localparam logic [7:0] OP_SET_WEL = 8'h06;
  localparam logic [7:0] OP_CLR_WEL = 8'h04;
  localparam logic [7:0] OP_STAT_RD = 8'h05;
  localparam logic [7:0] OP_STAT_WR = 8'h01;
  localparam logic [7:0] OP_ARR_RD  = 8'h03;
  localparam logic [7:0] OP_ARR_WR  = 8'h02;
  localparam logic [7:0] OP_ID_RD   = 8'h83;
  localparam logic [7:0] OP_ID_WR   = 8'h82;
  // Bit positions inside the status byte.
  localparam int ST_BUSY = 0;
  localparam int ST_WEL  = 1;
  localparam int ST_BP0  = 2;
  localparam int ST_BP1  = 3;
  localparam int ST_LOCK = 7;
  // Value of the stored protection bits on first power-up.
  localparam logic [1:0] BP_INIT   = 2'h0;
  localparam logic       LOCK_INIT = 1'b0;
  // Bytes needed before an array write may run: code, three address, data.
  localparam logic [2:0] WR_MIN_BYTES = 3'h5;
  // Bytes of a status write frame: code and one data byte.
  localparam logic [2:0] SW_BYTES = 3'h2;
  // Self-timed write cycle, in microseconds and in clock cycles.
  localparam int TW_US         = 5000;
  localparam int CLK_MHZ       = 50;
  localparam int TW_CYCLES_DEF = TW_US * CLK_MHZ;
  // Half period of the serial clock made by the host, in clock cycles.
  localparam int HALF_DIV = 4;
  // Host register byte offsets on APB.
  localparam logic [7:0] RA_TX_HI = 8'h00;
  localparam logic [7:0] RA_TX_LO = 8'h04;
  localparam logic [7:0] RA_CTRL  = 8'h08;
  localparam logic [7:0] RA_STAT  = 8'h0c;
  localparam logic [7:0] RA_RX    = 8'h10;
  // Host control fields.
  localparam int CT_LEN_LSB = 0;
  localparam int CT_START   = 4;
  localparam int CT_WP      = 5;
endpackage

// ==== verif/secsp_link_properties.sv ====
// Checker for the serial link between the host end and the device end.
// Assumes clk samples every link pin and nrst is synchronous, active low.
`timescale 1ns/100ps
module secsp_link_properties (
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic mosi,
  input wire logic miso,
  input wire logic misoOe,
  input wire logic wpN
);
  logic       sclkQ;   // Serial clock one sample back.
  logic [6:0] bitCnt;  // Serial rising edges seen in this frame.
  logic [7:0] opc;     // First byte of the frame.
  wire        sclkRise = sclk & ~sclkQ;
  wire        inOpc    = ~csN & sclkRise & (bitCnt < 7'h08);
  // Edge finder for the serial clock.
  always_ff @(posedge clk) begin
    sclkQ <= nrst & sclk;
  end
  // Saturates, so an endless status stream cannot wrap the count.
  always_ff @(posedge clk) begin
    if (!nrst || csN) begin
      bitCnt <= 7'h00;
    end else if (sclkRise && bitCnt != 7'h7f) begin
      bitCnt <= bitCnt + 7'h01;
    end
  end
  // Opcode capture, first eight bits only.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      opc <= 8'h00;
    end else if (inOpc) begin
      opc <= {opc[6:0], mosi};
    end
  end
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  property p_sclk_idle;
    csN |-> !sclk;
  endproperty
  a_sclk_idle: assert property (p_sclk_idle)
    else $error("serial clock not idle low while deselected");
  property p_mosi_stable;
    sclk && $past(sclk) |-> $stable(mosi);
  endproperty
  a_mosi_stable: assert property (p_mosi_stable)
    else $error("data in moved while serial clock high");
  property p_cs_edge;
    $changed(csN) |-> !sclk;
  endproperty
  a_cs_edge: assert property (p_cs_edge)
    else $error("select moved while serial clock high");
  property p_whole_bytes;
    $rose(csN) |-> bitCnt[2:0] == 3'h0 && bitCnt != 7'h00;
  endproperty
  a_whole_bytes: assert property (p_whole_bytes)
    else $error("frame ended off a byte boundary");
  property p_oe_status_op;
    $rose(misoOe) |-> opc == secsp_pkg::OP_STAT_RD && bitCnt >= 7'h08;
  endproperty
  a_oe_status_op: assert property (p_oe_status_op)
    else $error("data out driven without a status read");
  property p_oe_release;
    $rose(csN) |-> ##[1:8] !misoOe;
  endproperty
  a_oe_release: assert property (p_oe_release)
    else $error("data out still driven after deselect");
  property p_miso_stable;
    misoOe && sclk && $past(sclk) && $past(sclk, 2) |-> $stable(miso);
  endproperty
  a_miso_stable: assert property (p_miso_stable)
    else $error("data out moved while serial clock high");
  property p_zero_bits;
    sclkRise && misoOe && bitCnt >= 7'h08 && bitCnt[2:0] inside {1, 2, 3}
      |-> !miso;
  endproperty
  a_zero_bits: assert property (p_zero_bits)
    else $error("status bit six to four read as one");
  c_status: cover property ($rose(misoOe));
  c_array_wr: cover property ($rose(csN) && bitCnt == 7'h28);
  c_wp_low: cover property ($fell(wpN));
endmodule

// ==== verif/spi_eeprom_cmd_status_protect_test.sv ====
// Bench: host end and device end joined on one link, driven over APB.
// Assumes the package, the interface and both ends are compiled first.
`timescale 1ns/100ps
module spi_eeprom_cmd_status_protect_test;
  typedef struct packed {
    logic [31:0] m;
    logic [31:0] v;
    logic        e;
  } secsp_exp_s;
  localparam int TW = 400;  // Short write cycle keeps the run brief.
  localparam logic [7:0] BAD_OP = 8'ha5;
  localparam logic [7:0] OPS[9] = '{8'h06, 8'h04, 8'h05, 8'h01, 8'h03,
                                    8'h02, 8'h83, 8'h82, BAD_OP};
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic        chk = 1'b0;   // Marks a read whose data is checked.
  logic        wpOn = 1'b0;  // Protect request sent with each start.
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] lastRd = 32'h0;
  logic        pready, pslverr, cmdPulse, lockSel, hwProtected, writeStart;
  logic [7:0]  statusByte, cmdCode;
  logic        curLk = 1'b0;
  logic [1:0]  curBp = 2'h0;
  int          fail_count = 0;
  int          n_tests = 0;
  int          nWs = 0;      // Write-start pulses seen so far.
  logic [23:0] ad;           // Address sent with a decode frame.
  int          cyc = 0;
  secsp_exp_s  expQ[$];
  secsp_exp_s  e;
  logic [7:0]  opQ[$];
  logic [23:0] bnd[3] = '{24'h02ffff, 24'h030000, 24'h01ffff};
  always #10 clk = ~clk;
  secsp_link_if secsp_link_if_i ();
  secsp_dev_end #(.TW_CYCLES(TW)) secsp_dev_end_i (.clk(clk), .nrst(nrst),
    .link(secsp_link_if_i), .statusByte(statusByte), .cmdPulse(cmdPulse),
    .cmdCode(cmdCode), .lockSel(lockSel), .hwProtected(hwProtected),
    .writeStart(writeStart));
  secsp_host_end secsp_host_end_i (.clk(clk), .nrst(nrst),
    .link(secsp_link_if_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  secsp_link_properties secsp_link_properties_i (.clk(clk), .nrst(nrst),
    .sclk(secsp_link_if_i.sclk), .csN(secsp_link_if_i.csN),
    .mosi(secsp_link_if_i.mosi), .miso(secsp_link_if_i.miso),
    .misoOe(secsp_link_if_i.misoOe), .wpN(secsp_link_if_i.wpN));
  task automatic bad(input string s, input logic [31:0] x, g);
    fail_count++;
    $display("BAD %0t: %s want %h got %h", $time, s, x, g);
  endtask
  task automatic cmp_word(input logic [31:0] x, g);
    n_tests++;
    if (g !== x) bad("read data", x, g);
  endtask
  task automatic cmp_err(input logic x, g);
    n_tests++;
    if (g !== x) bad("flag", {31'h0, x}, {31'h0, g});
  endtask
  task automatic cmp_op(input logic [7:0] x, g);
    n_tests++;
    if (g !== x) bad("byte", {24'h0, x}, {24'h0, g});
  endtask
  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // One APB transfer; the request holds until pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic c);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    chk <= c;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    penable <= 1'b0;
    chk <= 1'b0;
    @(negedge clk);
  endtask
  // Notes the expected word, then reads it.
  task automatic expect_rd(input logic [7:0] a, input logic [31:0] m, v);
    expQ.push_back('{m, v, 1'b0});
    apb(1'b0, a, 32'h0, 1'b1);
  endtask
  // Sends len bytes, most significant first, and waits for the end.
  task automatic frame(input int len, input logic [63:0] d);
    int n;
    n = 0;
    if (d[63:56] !== BAD_OP) opQ.push_back(d[63:56]);
    apb(1'b1, secsp_pkg::RA_TX_HI, d[63:32], 1'b0);
    apb(1'b1, secsp_pkg::RA_TX_LO, d[31:0], 1'b0);
    apb(1'b1, secsp_pkg::RA_CTRL, (32'(len) << secsp_pkg::CT_LEN_LSB) |
        (32'h1 << secsp_pkg::CT_START) | (32'(!wpOn) << secsp_pkg::CT_WP),
        1'b0);
    do begin
      apb(1'b0, secsp_pkg::RA_STAT, 32'h0, 1'b0);
      n++;
    end while (lastRd[0] !== 1'b0 && n < 400);
    if (lastRd[0] !== 1'b0) bad("poll limit", 32'h0, 32'h0);
  endtask
  task automatic rd_status(input logic [7:0] x);
    frame(2, {secsp_pkg::OP_STAT_RD, 56'h0});
    expect_rd(secsp_pkg::RA_RX, 32'hff, {24'h0, x});
    cmp_op(x, statusByte);
    cmp_err(curLk & wpOn, hwProtected);
  endtask
  // Status write with junk in the bits that must not change.
  task automatic set_st(input logic lk, input logic [1:0] bp, input logic ok);
    frame(1, {secsp_pkg::OP_SET_WEL, 56'h0});
    frame(2, {secsp_pkg::OP_STAT_WR, lk, 3'($urandom), bp, 2'($urandom),
              48'h0});
    rd_status({curLk, 3'h0, curBp, 1'b1, ok});
    repeat (TW + 40) @(posedge clk);
    if (ok) begin
      curLk = lk;
      curBp = bp;
    end
    rd_status({curLk, 3'h0, curBp, ~ok, 1'b0});
    frame(1, {secsp_pkg::OP_CLR_WEL, 56'h0});
  endtask
  // Array write; refused inside the block-protected region.
  task automatic try_wr(input logic [23:0] a);
    logic acc;
    int w0;
    a[23:18] = 6'($urandom);
    acc = !(curBp == 2'h3 || (curBp == 2'h2 && a[17]) ||
            (curBp == 2'h1 && a[17:16] == 2'h3));
    w0 = nWs;
    frame(1, {secsp_pkg::OP_SET_WEL, 56'h0});
    frame(5, {secsp_pkg::OP_ARR_WR, a, 8'($urandom), 24'h0});
    rd_status({curLk, 3'h0, curBp, 1'b1, acc});
    cmp_err(acc, nWs != w0);
    repeat (TW + 40) @(posedge clk);
    frame(1, {secsp_pkg::OP_CLR_WEL, 56'h0});
  endtask
  // Watches finished reads and decoded opcodes against the notes.
  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1 && !pwrite) lastRd <= prdata;
    if (psel && penable && pready === 1'b1 && chk && expQ.size() > 0) begin
      e = expQ.pop_front();
      cmp_err(e.e, pslverr);
      if (!e.e) cmp_word(e.v, prdata & e.m);
    end
    if (cmdPulse === 1'b1 && opQ.size() > 0) cmp_op(opQ.pop_front(), cmdCode);
    if (writeStart === 1'b1) nWs++;
  end
  // A hang counts as a mismatch.
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      bad("timeout", 32'h0, 32'h0);
      report_and_stop();
    end
  end
  initial begin
    void'($urandom(88225));
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    rd_status(8'h00);
    expQ.push_back('{32'h0, 32'h0, 1'b1});
    apb(1'b0, 8'h40, 32'h0, 1'b1);
    $display("Test reset and map done");
    frame(1, {secsp_pkg::OP_SET_WEL, 56'h0});
    rd_status(8'h02);
    frame(1, {secsp_pkg::OP_CLR_WEL, 56'h0});
    rd_status(8'h00);
    frame(2, {secsp_pkg::OP_STAT_WR, 8'h8c, 48'h0});
    rd_status(8'h00);
    $display("Test latch done");
    foreach (OPS[i]) begin
      ad = 24'($urandom);
      frame(4, {OPS[i], ad, 32'h0});
      if ((OPS[i] | 8'h01) == secsp_pkg::OP_ID_RD) begin
        cmp_err(ad[10], lockSel);
      end
    end
    rd_status(8'h00);
    $display("Test decode done");
    for (int b = 0; b < 4; b++) begin
      set_st(1'b0, 2'(b), 1'b1);
      for (int k = 0; k < 4; k++) try_wr(k < 3 ? bnd[k] : 24'($urandom));
    end
    $display("Test block protect done");
    set_st(1'b1, 2'h1, 1'b1);
    frame(8, {secsp_pkg::OP_STAT_RD, 56'h0});
    expect_rd(secsp_pkg::RA_RX, 32'hffffffff, {4{8'h84}});
    wpOn = 1'b1;
    set_st(1'b0, 2'h2, 1'b0);
    try_wr(24'h000100);
    wpOn = 1'b0;
    set_st(1'b0, 2'h0, 1'b1);
    wpOn = 1'b1;
    set_st(1'b0, 2'h3, 1'b1);
    wpOn = 1'b0;
    set_st(1'b0, 2'h0, 1'b1);
    $display("Test hardware protect done");
    report_and_stop();
  end
endmodule
